// ==== rtl/sgcfg_regs.vh ====
// offsets, field positions, reset values and timing for the switch config block
`ifndef SGCFG_REGS_VH
`define SGCFG_REGS_VH
`define SGC_CLK_HZ        125000000
`define SGC_FLASH_HZ      1
`define SGC_ORANGE_MS     250
`define SGC_DEBOUNCE_MS   10
`define SGC_HALF_FLASH_CYC (`SGC_CLK_HZ / (2 * `SGC_FLASH_HZ))
`define SGC_ORANGE_CYC    ((`SGC_CLK_HZ / 1000) * `SGC_ORANGE_MS)
`define SGC_DEBOUNCE_CYC  ((`SGC_CLK_HZ / 1000) * `SGC_DEBOUNCE_MS)
`define SGC_OFS_EXT_CFG   12'h000
`define SGC_OFS_EXT_WDOG  12'h004
`define SGC_OFS_STATUS    12'h008
`define SGC_EXT_ADDR_LSB  0
`define SGC_EXT_RATE_LSB  8
`define SGC_EXT_PAR_LSB   11
`define SGC_EXT_ASCII_BIT 13
`define SGC_ST_EXT_BIT    14
`define SGC_ST_RS232_BIT  15
`define SGC_ST_TERM_BIT   16
`define SGC_ST_STORE_BIT  17
`define SGC_ST_DONE_BIT   18
`define SGC_EXT_ADDR_RST  8'h01
`define SGC_EXT_ADDR_MAX  8'hF7
`define SGC_WDOG_RST      16'h0000
`define SGC_RATE_9K6      3'h0
`define SGC_RATE_19K2     3'h1
`define SGC_RATE_38K4     3'h2
`define SGC_RATE_57K6     3'h3
`define SGC_RATE_115K2    3'h4
`define SGC_PAR_NONE      2'h0
`define SGC_PAR_EVEN      2'h1
`define SGC_PAR_ODD       2'h2
`define SGC_DATA_BITS     4'h8
`define SGC_STOP_BITS     2'h1
`define SGC_LED_OFF       2'h0
`define SGC_LED_GREEN     2'h1
`define SGC_LED_RED       2'h2
`define SGC_LED_ORANGE    2'h3
`endif

// ==== rtl/sgcfg_top.v ====
// switch decode, extended parameters, config store sequencing and apb registers
//
// Overview of operation
// - standard mode: 8 data, even, 1 stop, RTU
// - address is weighted sum of five switches
// - address switches zero select extended mode
// - extended mode accepts address 1 to 247
// - rate switches 6,7 pick four bit rates
// - 57.6 kbps only via extended parameters
// - one switch selects RS232 or RS485
// - termination on only while its switch on
// - store switch off-to-on starts configuration copy
// - storing: orange briefly, then green 1 Hz flash
// - switch held on restarts storage; off ends
// - after storage both status LEDs steady green
// - extended mode: tool parity, mode, watchdog used
// - no module bus address; switches only fieldbus
`timescale 1ns/1ps
`default_nettype none
`include "sgcfg_regs.vh"

module sgcfg_top #(
   parameter integer HALF_FLASH_CYC = `SGC_HALF_FLASH_CYC,
   parameter integer ORANGE_CYC     = `SGC_ORANGE_CYC,
   parameter integer DEBOUNCE_CYC   = `SGC_DEBOUNCE_CYC
) (
   input  wire        clk,
   input  wire        nrst,
   // apb register port
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // front panel switches, static levels
   input  wire [4:0]  sw_addr,
   input  wire        sw_rate6,
   input  wire        sw_rate7,
   input  wire        sw_if_rs232,
   input  wire        sw_term,
   input  wire        sw_store,
   // non-volatile store handshake
   input  wire        nvm_store_done,
   output reg         nvm_store_start,
   // effective line configuration
   output reg  [7:0]  node_addr,
   output reg  [2:0]  bit_rate,
   output reg  [3:0]  data_bits,
   output reg  [1:0]  parity,
   output reg  [1:0]  stop_bits,
   output reg         ascii_mode,
   output reg  [15:0] wdog_time,
   output reg         ext_mode,
   output reg         rs232_sel,
   output reg         term_en,
   output reg         storing,
   // status leds
   output reg  [1:0]  module_status_led,
   output reg  [1:0]  gateway_status_led
);

   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_ORANGE = 2'h1;
   localparam [1:0] ST_ACTIVE = 2'h2;

   // extended parameters written by the configuration tool
   reg  [7:0]  ext_addr_q;
   reg  [2:0]  ext_rate_q;
   reg  [1:0]  ext_par_q;
   reg         ext_ascii_q;
   reg  [15:0] ext_wdog_q;
   // store switch conditioning
   reg         sync1_q;
   reg         sync2_q;
   reg         deb_q;
   reg  [31:0] deb_cnt_q;
   // store sequencer
   reg  [1:0]  state_q;
   reg  [31:0] tmr_q;
   reg         flash_q;
   reg         done_q;

   // decode and handshake terms
   wire        wr_en;
   wire        rd_en;
   wire [2:0]  sel;
   wire        is_ext;
   wire [2:0]  sw_rate;
   wire [7:0]  wr_addr;
   wire [2:0]  wr_rate;
   wire [1:0]  wr_par;
   wire        deb_rise;
   wire        deb_fall;

   // one-hot register select, shared by error, read and write decode
   function [2:0] reg_sel;
      input [11:0] a;
      begin
         if (a == `SGC_OFS_EXT_CFG) begin
            reg_sel = 3'h1;
         end else if (a == `SGC_OFS_EXT_WDOG) begin
            reg_sel = 3'h2;
         end else if (a == `SGC_OFS_STATUS) begin
            reg_sel = 3'h4;
         end else begin
            reg_sel = 3'h0;
         end
      end
   endfunction

   // only the fieldbus node takes a switch address, the module bus needs none
   assign is_ext  = (sw_addr == 5'h00);

   // node address as the sum of the weights of the switches that are set
   wire [7:0]  addr_sum [0:5];
   genvar      gi;
   assign addr_sum[0] = 8'h00;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_addr_weight
         assign addr_sum[gi + 1] = addr_sum[gi] +
                                   (sw_addr[gi] ? (8'h01 << gi) : 8'h00);
      end
   endgenerate

   // switch table never yields the 57.6 code
   assign sw_rate = {sw_rate7 & sw_rate6, sw_rate7 & ~sw_rate6,
                     sw_rate6 & ~sw_rate7};
   assign sel     = reg_sel(paddr);
   // writes wait for the completing edge, never the first access cycle
   assign wr_en   = psel & penable & pready & pwrite;
   // read data is caught a cycle early so it stands beside pready
   assign rd_en   = psel & penable & ~pready & ~pwrite;
   assign wr_addr = pwdata[`SGC_EXT_ADDR_LSB +: 8];
   assign wr_rate = pwdata[`SGC_EXT_RATE_LSB +: 3];
   assign wr_par  = pwdata[`SGC_EXT_PAR_LSB +: 2];
   // rise and fall are decided on the edge that flips the accepted level
   assign deb_rise = deb_q == 1'b0 && sync2_q == 1'b1 &&
                     deb_cnt_q == DEBOUNCE_CYC - 1;
   assign deb_fall = deb_q == 1'b1 && sync2_q == 1'b0 &&
                     deb_cnt_q == DEBOUNCE_CYC - 1;

   // apb slave: one wait state, write lands on the completing edge
   always @(posedge clk) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~(|sel);
         if (rd_en) begin
            if (sel[0]) begin
               prdata <= {18'h00000,
                          ext_ascii_q,
                          ext_par_q,
                          ext_rate_q,
                          ext_addr_q};
            end else if (sel[1]) begin
               prdata <= {16'h0000, ext_wdog_q};
            end else if (sel[2]) begin
               prdata <= {13'h0000,
                          done_q,
                          storing,
                          term_en,
                          rs232_sel,
                          ext_mode,
                          ascii_mode,
                          parity,
                          bit_rate,
                          node_addr};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

   // extended register writes; out-of-range fields keep their old value
   always @(posedge clk) begin
      if (!nrst) begin
         // reset leaves the tool set at standard framing
         ext_addr_q  <= `SGC_EXT_ADDR_RST;
         ext_rate_q  <= `SGC_RATE_9K6;
         ext_par_q   <= `SGC_PAR_EVEN;
         ext_ascii_q <= 1'b0;
         ext_wdog_q  <= `SGC_WDOG_RST;
      end else if (wr_en) begin
         if (sel[0]) begin
            if (wr_addr != 8'h00 && wr_addr <= `SGC_EXT_ADDR_MAX) begin
               ext_addr_q <= wr_addr;
            end
            if (wr_rate <= `SGC_RATE_115K2) begin
               ext_rate_q <= wr_rate;
            end
            if (wr_par != 2'h3) begin
               ext_par_q <= wr_par;
            end
            ext_ascii_q <= pwdata[`SGC_EXT_ASCII_BIT];
         end else if (sel[1]) begin
            ext_wdog_q <= pwdata[15:0];
         end
      end
   end

   // data and stop bits are fixed in both modes, the tool cannot change them
   always @(posedge clk) begin
      if (!nrst) begin
         data_bits <= `SGC_DATA_BITS;
         stop_bits <= `SGC_STOP_BITS;
      end else begin
         data_bits <= `SGC_DATA_BITS;
         stop_bits <= `SGC_STOP_BITS;
      end
   end

   // interface choice and termination apply in either mode
   always @(posedge clk) begin
      if (!nrst) begin
         rs232_sel <= 1'b0;
         term_en   <= 1'b0;
      end else begin
         rs232_sel <= sw_if_rs232;
         // termination is an rs485 matter only
         term_en   <= sw_term & ~sw_if_rs232;
      end
   end

   // effective line configuration, recomputed every cycle from switches or, in extended mode, from the extended registers
   always @(posedge clk) begin
      if (!nrst) begin
         node_addr  <= 8'h00;
         bit_rate   <= `SGC_RATE_9K6;
         parity     <= `SGC_PAR_EVEN;
         ascii_mode <= 1'b0;
         wdog_time  <= `SGC_WDOG_RST;
         ext_mode   <= 1'b0;
      end else begin
         ext_mode  <= is_ext;
         if (is_ext) begin
            node_addr  <= ext_addr_q;
            bit_rate   <= ext_rate_q;
            parity     <= ext_par_q;
            ascii_mode <= ext_ascii_q;
            wdog_time  <= ext_wdog_q;
         end else begin
            node_addr  <= addr_sum[5];
            bit_rate   <= sw_rate;
            parity     <= `SGC_PAR_EVEN;
            ascii_mode <= 1'b0;
            wdog_time  <= `SGC_WDOG_RST;
         end
      end
   end

   // two-flop sync, then level must hold a full window to be accepted
   always @(posedge clk) begin
      if (!nrst) begin
         sync1_q   <= 1'b0;
         sync2_q   <= 1'b0;
         deb_q     <= 1'b0;
         deb_cnt_q <= 32'h0000_0000;
      end else begin
         sync1_q <= sw_store;
         sync2_q <= sync1_q;
         if (sync2_q == deb_q) begin
            deb_cnt_q <= 32'h0000_0000;
         end else if (deb_cnt_q == DEBOUNCE_CYC - 1) begin
            deb_cnt_q <= 32'h0000_0000;
            deb_q     <= sync2_q;
         end else begin
            deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
         end
      end
   end

   // store sequencer; a switch held high at reset release counts as a rise
   always @(posedge clk) begin
      if (!nrst) begin
         state_q         <= ST_IDLE;
         tmr_q           <= 32'h0000_0000;
         flash_q         <= 1'b0;
         done_q          <= 1'b0;
         nvm_store_start <= 1'b0;
         storing         <= 1'b0;
      end else begin
         nvm_store_start <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (deb_rise) begin
                  state_q         <= ST_ORANGE;
                  tmr_q           <= 32'h0000_0000;
                  nvm_store_start <= 1'b1;
                  storing         <= 1'b1;
                  done_q          <= 1'b0;
               end
            end
            // orange shows once per storage, restarts keep flashing
            ST_ORANGE, ST_ACTIVE: begin
               if (deb_fall) begin
                  state_q <= ST_IDLE;
                  storing <= 1'b0;
                  done_q  <= 1'b1;
               end else begin
                  // a finished pass starts the next while the switch stays on
                  if (nvm_store_done) begin
                     nvm_store_start <= 1'b1;
                  end
                  if (state_q == ST_ORANGE && tmr_q == ORANGE_CYC - 1) begin
                     state_q <= ST_ACTIVE;
                     tmr_q   <= 32'h0000_0000;
                     flash_q <= 1'b1;
                  end else if (state_q == ST_ACTIVE && tmr_q == HALF_FLASH_CYC - 1) begin
                     tmr_q   <= 32'h0000_0000;
                     flash_q <= ~flash_q;
                  end else begin
                     tmr_q <= tmr_q + 32'h0000_0001;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // led colours follow the sequencer one cycle later
   always @(posedge clk) begin
      if (!nrst) begin
         module_status_led  <= `SGC_LED_OFF;
         gateway_status_led <= `SGC_LED_OFF;
      end else begin
         gateway_status_led <= `SGC_LED_GREEN;
         if (state_q == ST_ORANGE) begin
            module_status_led <= `SGC_LED_ORANGE;
         end else if (state_q == ST_ACTIVE) begin
            module_status_led <= flash_q ? `SGC_LED_GREEN : `SGC_LED_OFF;
         end else begin
            module_status_led <= `SGC_LED_GREEN;
         end
      end
   end

endmodule // sgcfg_top

`default_nettype wire

// ==== testbench/sgcfg_asserts.sv ====
// assertion checker for the switch config block
`timescale 1ns/1ps
`default_nettype none
module sgcfg_chk (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [4:0] sw_addr,
   input wire logic       sw_rate6,
   input wire logic       sw_rate7,
   input wire logic       sw_if_rs232,
   input wire logic       sw_term,
   input wire logic       sw_store,
   input wire logic       nvm_store_done,
   input wire logic       nvm_store_start,
   input wire logic [7:0] node_addr,
   input wire logic [2:0] bit_rate,
   input wire logic [3:0] data_bits,
   input wire logic [1:0] parity,
   input wire logic [1:0] stop_bits,
   input wire logic       ascii_mode,
   input wire logic       ext_mode,
   input wire logic       rs232_sel,
   input wire logic       term_en,
   input wire logic       storing,
   input wire logic [1:0] module_status_led,
   input wire logic [1:0] gateway_status_led
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // past reset guard: outputs lag their switch by one cycle
   sequence s_std; $past(nrst) && $past(sw_addr) != 5'h00; endsequence
   sequence s_go; $rose(storing); endsequence
   a_std_frame: assert property (
      !ext_mode |-> data_bits == 4'h8 && stop_bits == 2'h1 && parity == 2'h1 && !ascii_mode)
      else $error("standard framing wrong");
   a_std_addr: assert property (
      s_std |-> node_addr == {3'h0, $past(sw_addr)} && !ext_mode) else $error("bad address");
   a_ext_select: assert property (
      $past(nrst) && $past(sw_addr) == 5'h00 |-> ext_mode) else $error("no ext mode");
   a_ext_range: assert property (
      ext_mode |-> node_addr >= 8'h01 && node_addr <= 8'hF7) else $error("ext addr range");
   a_rate_decode: assert property (
      s_std |-> bit_rate == ({$past(sw_rate7), $past(sw_rate6)} == 2'h3 ? 3'h4
      : {1'h0, $past(sw_rate7), $past(sw_rate6)})) else $error("bad rate");
   a_if_term: assert property (
      $past(nrst) |-> rs232_sel == $past(sw_if_rs232)
      && term_en == ($past(sw_term) && !$past(sw_if_rs232))) else $error("bad if or term");
   a_debounced_go: assert property (
      s_go |-> $past(sw_store, 3) && $past(sw_store, 4) && $past(sw_store, 5)
      && $past(sw_store, 6)) else $error("store on bounce");
   a_start_pulse: assert property (
      s_go |-> nvm_store_start || $past(nvm_store_start)) else $error("no start");
   a_orange_first: assert property (
      s_go |=> (module_status_led == 2'h3)[*2]) else $error("no orange");
   a_restart: assert property (
      storing && nvm_store_done ##1 storing |-> nvm_store_start) else $error("no restart");
   a_end_green: assert property (
      $fell(storing) |=> module_status_led == 2'h1 && gateway_status_led == 2'h1)
      else $error("not green");
endmodule // sgcfg_chk
bind sgcfg_top sgcfg_chk u_chk (.clk(clk), .nrst(nrst), .sw_addr(sw_addr),
   .sw_rate6(sw_rate6), .sw_rate7(sw_rate7), .sw_if_rs232(sw_if_rs232), .sw_term(sw_term),
   .sw_store(sw_store), .nvm_store_done(nvm_store_done), .nvm_store_start(nvm_store_start),
   .node_addr(node_addr), .bit_rate(bit_rate), .data_bits(data_bits), .parity(parity),
   .stop_bits(stop_bits), .ascii_mode(ascii_mode), .ext_mode(ext_mode),
   .rs232_sel(rs232_sel), .term_en(term_en), .storing(storing),
   .module_status_led(module_status_led), .gateway_status_led(gateway_status_led));
`default_nettype wire

// ==== testbench/sgcfg_nvm.sv ====
// behavioural non-volatile store answering each storage pass
`timescale 1ns/1ps
`default_nettype none
module sgcfg_nvm (
   input wire logic clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic start,
   output var logic done
);
   int cnt;
   // slow passes stretch the restart spacing
   always @(posedge clk) begin
      done <= 1'b0;
      if (!nrst)
         cnt <= 0;
      else if (start)
         cnt <= slow ? 9 : 2;
      else if (cnt == 1) begin
         cnt <= 0;
         done <= 1'b1;
      end else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule // sgcfg_nvm
`default_nettype wire

// ==== testbench/tb_serial_gateway_switch_config.sv ====
// self-checking bench for the switch config block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_serial_gateway_switch_config;
   logic        clk, nrst, psel, penable, pwrite, r6, r7, rs232, term, store, slow;
   logic        pready, pslverr, ascii, ext, rsel, ten, storing, done, start;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [32:0] expq[$];
   logic [4:0]  swa;
   logic [7:0]  naddr;
   logic [2:0]  rate;
   logic [3:0]  dbits, seen;
   logic [1:0]  par, sbits, mled, gled;
   logic [15:0] wdog;
   int          errors, n_compared, cyc, seed, i, n_start;
   sgcfg_top #(.HALF_FLASH_CYC(6), .ORANGE_CYC(5), .DEBOUNCE_CYC(4)) dut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sw_addr(swa), .sw_rate6(r6), .sw_rate7(r7), .sw_if_rs232(rs232), .sw_term(term),
      .sw_store(store), .nvm_store_done(done), .nvm_store_start(start), .node_addr(naddr),
      .bit_rate(rate), .data_bits(dbits), .parity(par), .stop_bits(sbits),
      .ascii_mode(ascii), .wdog_time(wdog), .ext_mode(ext), .rs232_sel(rsel),
      .term_en(ten), .storing(storing), .module_status_led(mled), .gateway_status_led(gled));
   sgcfg_nvm nvm (.clk(clk), .nrst(nrst), .slow(slow), .start(start), .done(done));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic conclude();
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one transfer; e holds expected {pslverr, read data}
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] st_exp(input logic [31:0] cfg);
      logic [2:0] rc;
      rc = (r6 && r7) ? 3'h4 : {1'b0, r7, r6};
      return ((swa == 5'h00) ? (cfg | 32'h4000) : ({27'h0, swa} | {21'h0, rc, 8'h0} | 32'h800))
         | {15'h0, term & ~rs232, rs232, 15'h0};
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (start === 1'b1) n_start++;
      if (storing === 1'b1) seen[mled] = 1'b1;
      if (psel && penable && pready === 1'b1) begin
         `CHK({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front())
      end
      if (cyc == 5000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      {nrst, psel, penable, pwrite, r6, r7, rs232, term, store, slow} = 10'h000;
      {paddr, pwdata, swa, seen} = 53'h0;
      seed = 57676;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0801);
      apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
      apb(1'b1, 12'h000, 32'h33F7, 33'h0);
      apb(1'b1, 12'h000, 32'h3DF8, 33'h0);
      apb(1'b0, 12'h000, 32'h0, 33'h0_0000_33F7);
      apb(1'b1, 12'h004, 32'h1234, 33'h0);
      for (i = 0; i < 24; i++) begin
         v = $random(seed);
         swa <= (i % 5 == 0) ? 5'h00 : v[4:0];
         {r7, r6} <= i[1:0];
         {rs232, term} <= v[9:8];
         repeat (2) @(posedge clk);
         `CHK(wdog, swa == 5'h00 ? 16'h1234 : 16'h0000)
         `CHK({dbits, sbits}, 6'h21)
         apb(1'b0, 12'h008, 32'h0, {1'b0, st_exp(32'h33F7)});
      end
      swa <= 5'h1B;
      store <= 1'b1;
      repeat (3) @(posedge clk);
      store <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK(storing, 1'b0)
      n_start = 0;
      store <= 1'b1;
      repeat (60) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0, {1'b0, st_exp(32'h33F7) | 32'h0002_0000});
      slow <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK(n_start > 8, 1'b1)
      `CHK(seen, 4'hB)
      store <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK(storing, 1'b0)
      `CHK({mled, gled}, 4'h5)
      apb(1'b0, 12'h008, 32'h0, {1'b0, st_exp(32'h33F7) | 32'h0004_0000});
      conclude();
   end
endmodule // tb_serial_gateway_switch_config
`default_nettype wire
